/* rtl/rsq_sequencer.sv */
/*
  Reset sequencer, stabilisation counter and interrupt arbiter of the system
  integration unit. Holds the reset cause register and option register one.
  Assumes clk is the reference clock, the reset pin and test voltage detectors are
  asynchronous, and all core signals are synchronous to clk.
*/
// The plain strobed port and the register addresses were decided locally.
`default_nettype none
// How it works
// [R1] Every reset asserts internal reset, selects vector
// [R2] Internal reset clears counter; pin reset does not
// [R3] Pin flag needs 67 or 4163 low cycles
// [R4] Drive pin 32 cycles, hold 32 more
// [R5] Power/voltage resets first count 4096 cycles
// [R6] Power-on: pulse, clocks off, release later
// [R7] Power-on sets only power-on cause flag
// [R8] Watchdog overflow resets and sets flag
// [R9] Service write clears watchdog and counter bits
// [R10] Thirteen-bit counter overflow clocks the watchdog
// [R11] Watchdog disabled only by qualified test voltage
// [R12] Undefined instruction sets flag and resets
// [R13] Stop disallowed means stop is illegal
// [R14] Only unmapped opcode fetch causes reset
// [R15] Low voltage sets flag, long reset sequence
// [R16] Stop clears counter; recovery 32 or 4096
// [R17] Counter runs freely after reset completes
// [R18] Entry stacks without high index, sets mask
// [R19] Latched interrupt keeps precedence until serviced
// [R20] Hardware interrupt only at unmasked boundary
// [R21] Highest priority pending interrupt served first
// [R22] Software interrupt ignores mask, pushes PC
module rsq_sequencer
  import rsq_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic powerOnPulse,
  input wire logic lowVoltage,
  input wire logic watchdogOverflow,
  input wire logic badOpcode,
  input wire logic stopInstr,
  input wire logic opcodeFetch,
  input wire logic unmappedAddr,
  input wire logic stopWake,
  input wire logic monitorMode,
  input wire logic breakState,
  input wire logic resetPinIn,
  input wire logic testVoltRst,
  input wire logic testVoltIrq,
  input wire logic serviceWrite,
  input wire rsq_core_type core,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic internalReset,
  output logic busClocksOn,
  output logic clockSourceOut,
  output logic [15:0] resetVector,
  output logic watchdogClear,
  output logic watchdogTick,
  output logic watchdogDisable,
  output rsq_exc_type exc
);
  rsq_state_type state_q;
  logic [12:0] stab_q;
  logic [12:0] phase_q;
  logic [12:0] pinLow_q;
  logic [7:0] cause_q;
  logic [7:0] option_q;
  logic [RSQ_NUM_IRQ-1:0] irqEn_q;
  logic [RSQ_NUM_IRQ-1:0] latched_q;
  logic latchedValid_q;
  logic longSeq_q;
  logic pinSync;
  logic rstVolt;
  logic irqVolt;
  logic rstVoltN;
  logic irqVoltN;
  logic stopIllegal;
  logic fetchBad;
  logic intSource;
  logic [7:0] pendMasked;

  // Returns the index of the highest priority request; bit 0 is the highest.
  function automatic logic [2:0] rsqPick(input logic [RSQ_NUM_IRQ-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = RSQ_NUM_IRQ - 1; i >= 0; i--)
      if (v[i])
        idx = 3'(i);
    return idx;
  endfunction

  rsq_sync u_pin (.clk(clk), .reset_n(reset_n), .asyncIn(resetPinIn), .syncOut(pinSync));
  rsq_sync u_vr (.clk(clk), .reset_n(reset_n), .asyncIn(!testVoltRst), .syncOut(rstVoltN));
  rsq_sync u_vi (.clk(clk), .reset_n(reset_n), .asyncIn(!testVoltIrq), .syncOut(irqVoltN));

  // The detectors idle low, so they pass inverted to match the synchroniser's high reset.
  assign rstVolt = !rstVoltN;
  assign irqVolt = !irqVoltN;

  // Internal reset sources; a stop with stop disallowed counts as a bad opcode.
  assign stopIllegal = stopInstr && !option_q[RSQ_BIT_STOP_ALLOW]; // [R13]
  assign fetchBad = opcodeFetch && unmappedAddr; // [R14]
  assign intSource = powerOnPulse || lowVoltage || (watchdogOverflow && !watchdogDisable)
                     || badOpcode || stopIllegal || fetchBad; // [R8] [R12]

  // Watchdog disable is qualified by the synchronised test voltage detectors.
  assign watchdogDisable = (monitorMode && (rstVolt || irqVolt))
                           || (breakState && rstVolt); // [R11]

  // Sequencer state, phase counter and long-sequence marker.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= RSQ_STAB;
      phase_q <= 13'h0000;
      longSeq_q <= 1'b1;
    end
    else if (powerOnPulse || lowVoltage)
    begin
      state_q <= RSQ_STAB; // [R5] [R15]
      phase_q <= 13'h0000;
      longSeq_q <= 1'b1;
    end
    else if (intSource && !(state_q == RSQ_STAB && longSeq_q))
    begin
      state_q <= RSQ_DRIVE; // [R4]
      phase_q <= 13'h0000;
      longSeq_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        RSQ_RUN:
        begin
          if (!pinSync)
            state_q <= RSQ_EXTRST;
          else if (stopInstr && option_q[RSQ_BIT_STOP_ALLOW])
            state_q <= RSQ_STOP;
        end
        RSQ_STAB:
        begin
          if (stab_q == RSQ_STAB_CYCLES - 13'h0001
              || (!longSeq_q && option_q[RSQ_BIT_SHORT_REC]
                  && stab_q == RSQ_SHORT_REC_CYCLES - 13'h0001))
          begin
            state_q <= longSeq_q ? RSQ_DRIVE : RSQ_RUN; // [R5] [R16]
            phase_q <= 13'h0000;
          end
        end
        RSQ_DRIVE:
        begin
          phase_q <= phase_q + 13'h0001;
          if (phase_q == RSQ_PIN_DRIVE_CYCLES - 13'h0001)
          begin
            state_q <= RSQ_HOLD; // [R4]
            phase_q <= 13'h0000;
          end
        end
        RSQ_HOLD:
        begin
          phase_q <= phase_q + 13'h0001;
          if (phase_q == RSQ_HOLD_CYCLES - 13'h0001)
          begin
            state_q <= RSQ_RUN; // [R6]
            longSeq_q <= 1'b0;
          end
        end
        RSQ_STOP:
        begin
          if (stopWake)
          begin
            state_q <= RSQ_STAB; // [R16]
            longSeq_q <= 1'b0;
          end
        end
        RSQ_EXTRST:
        begin
          if (pinSync)
            state_q <= RSQ_HOLD;
          phase_q <= 13'h0000;
        end
        default:
          state_q <= RSQ_STAB;
      endcase
    end
  end

  // Stabilisation counter: cleared by internal resets and stop, bits 12..4 by service.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      stab_q <= 13'h0000;
    else if (intSource || (stopInstr && option_q[RSQ_BIT_STOP_ALLOW])) // [R2] [R16]
      stab_q <= 13'h0000;
    else if (serviceWrite)
      stab_q <= {9'h000, stab_q[3:0] + 4'h1}; // [R9]
    else if (state_q != RSQ_STOP)
      stab_q <= stab_q + 13'h0001; // [R10] [R17]
  end

  // Watchdog tick is the counter overflow; the service write also clears the watchdog.
  assign watchdogTick = (stab_q == 13'h1FFF) && !serviceWrite && state_q != RSQ_STOP; // [R10]
  assign watchdogClear = serviceWrite; // [R9]

  // Count how long the synchronised reset pin has stayed low.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pinLow_q <= 13'h0000;
    else if (pinSync)
      pinLow_q <= 13'h0000;
    else if (pinLow_q != 13'h1FFF)
      pinLow_q <= pinLow_q + 13'h0001;
  end

  // Reset cause register; power-on wipes every other cause.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cause_q <= RSQ_CAUSE_POR_VALUE;
    else if (powerOnPulse)
      cause_q <= RSQ_CAUSE_POR_VALUE; // [R7]
    else
    begin
      if (!pinSync && !resetPinOe
          && pinLow_q == (longSeq_q ? RSQ_PIN_MIN_POR_CYCLES : RSQ_PIN_MIN_CYCLES) - 13'h0001)
        cause_q[RSQ_BIT_PIN] <= 1'b1; // [R3]
      if (watchdogOverflow && !watchdogDisable)
        cause_q[RSQ_BIT_WATCHDOG] <= 1'b1; // [R8]
      if (badOpcode || stopIllegal)
        cause_q[RSQ_BIT_BADINSTR] <= 1'b1; // [R12] [R13]
      if (fetchBad)
        cause_q[RSQ_BIT_BADFETCH] <= 1'b1; // [R14]
      if (lowVoltage)
        cause_q[RSQ_BIT_LOWVOLT] <= 1'b1; // [R15]
    end
  end

  // Option register one and interrupt enables, written by software.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      option_q <= RSQ_OPTION_RESET;
      irqEn_q <= 8'h00;
    end
    else if (internalReset)
    begin
      option_q <= RSQ_OPTION_RESET; // [R1]
      irqEn_q <= 8'h00;
    end
    else if (regWr && regAddr == RSQ_ADDR_OPTION)
      option_q <= regWdata;
    else if (regWr && regAddr == RSQ_ADDR_IRQ_ENABLE)
      irqEn_q <= regWdata;
  end

  // Read data one cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata <= 8'h00;
    else if (regRd)
    begin
      case (regAddr)
        RSQ_ADDR_CAUSE: regRdata <= cause_q;
        RSQ_ADDR_OPTION: regRdata <= option_q;
        RSQ_ADDR_COUNTER_LO: regRdata <= stab_q[7:0];
        RSQ_ADDR_COUNTER_HI: regRdata <= {3'h0, stab_q[12:8]};
        RSQ_ADDR_IRQ_ENABLE: regRdata <= irqEn_q;
        RSQ_ADDR_IRQ_PEND: regRdata <= core.req & irqEn_q;
        default: regRdata <= 8'h00;
      endcase
    end
    else
      regRdata <= 8'h00;
  end

  // Reset pin, internal reset and bus clock outputs follow the sequencer state; the clock source output stays on.
  assign resetPinOe = (state_q == RSQ_STAB && longSeq_q) || state_q == RSQ_DRIVE; // [R4] [R5]
  assign resetPinOut = 1'b0;
  assign internalReset = state_q == RSQ_STAB && longSeq_q || state_q == RSQ_DRIVE
                         || state_q == RSQ_HOLD || state_q == RSQ_EXTRST; // [R1]
  assign busClocksOn = state_q == RSQ_RUN || state_q == RSQ_HOLD; // [R6]
  assign clockSourceOut = 1'b1; // [R6]
  assign resetVector = monitorMode ? RSQ_VEC_MONITOR : RSQ_VEC_USER; // [R1]

  // Interrupt latch: a latched request keeps precedence until serviced or unmasked.
  assign pendMasked = core.req & irqEn_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latched_q <= 8'h00;
      latchedValid_q <= 1'b0;
    end
    else if (internalReset || exc.take || !core.maskBit && latchedValid_q && !core.boundary)
    begin
      latched_q <= 8'h00; // [R19]
      latchedValid_q <= 1'b0;
    end
    else if (!latchedValid_q && pendMasked != 8'h00)
    begin
      latched_q <= pendMasked; // [R19]
      latchedValid_q <= 1'b1;
    end
  end

  // Exception answer: software interrupt ignores the mask; hardware waits for a boundary.
  always_comb
  begin
    exc = '0;
    if (!internalReset && core.boundary)
    begin
      if (core.swInstr)
      begin
        exc.take = 1'b1; // [R22]
        exc.isSoft = 1'b1;
      end
      else if (!core.maskBit && (latchedValid_q || pendMasked != 8'h00)) // [R20]
      begin
        exc.take = 1'b1;
        exc.vecIndex = rsqPick(latchedValid_q ? latched_q : pendMasked); // [R21]
        exc.pushPcMinusOne = 1'b1; // [R22]
      end
      exc.setMask = exc.take; // [R18]
    end
  end

  AST_PIN_DRIVEN: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    $rose(state_q == RSQ_DRIVE) |-> resetPinOe [*8] ##25 !resetPinOe ##0 internalReset)
    else $error("Reset pin not driven for the drive period.");
  AST_HOLD_LEN: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    $rose(state_q == RSQ_HOLD) && !intSource |-> ##31 internalReset)
    else $error("Internal reset released early.");
  AST_POR_CAUSE: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    powerOnPulse |=> cause_q == RSQ_CAUSE_POR_VALUE)
    else $error("Power-on cause not exclusive.");
  AST_WDOG_FLAG: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    watchdogOverflow && !watchdogDisable |=> cause_q[RSQ_BIT_WATCHDOG] && internalReset)
    else $error("Watchdog reset not taken.");
  AST_SERVICE: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    serviceWrite && !intSource && state_q != RSQ_STAB |=> stab_q[12:4] == 9'h000)
    else $error("Service write did not clear counter.");
  AST_DATA_ACCESS: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
    unmappedAddr && !opcodeFetch && !powerOnPulse
    |=> !cause_q[RSQ_BIT_BADFETCH] || $past(cause_q[RSQ_BIT_BADFETCH]))
    else $error("Data access set bad fetch flag.");
  AST_MASKED: assert property (@(posedge clk) disable iff (!reset_n) // [R20]
    core.maskBit && !core.swInstr |-> !exc.take)
    else $error("Masked interrupt taken.");
  AST_SOFT: assert property (@(posedge clk) disable iff (!reset_n) // [R22]
    core.boundary && core.swInstr && !internalReset
    |-> exc.take && exc.isSoft && !exc.pushPcMinusOne)
    else $error("Software interrupt not taken.");
  AST_ILLEGAL_STOP: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
    stopInstr && !option_q[RSQ_BIT_STOP_ALLOW] && !powerOnPulse |=> cause_q[RSQ_BIT_BADINSTR])
    else $error("Illegal stop not flagged.");
  AST_PIN_KEEPS_COUNT: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    state_q == RSQ_EXTRST && !intSource && !serviceWrite && !stopInstr
    |=> stab_q == $past(stab_q) + 13'h0001)
    else $error("Pin reset disturbed the counter.");
endmodule
`default_nettype wire

/* rtl/rsq_pkg.sv */
/*
  Package of the reset and exception sequencer: register offsets, field positions,
  reset values, timing counts and shared types.
  Assumes a single 25 MHz clock, which stands in for the oscillator reference clock.
*/
`default_nettype none
package rsq_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] RSQ_ADDR_CAUSE = 4'h1;
  localparam logic [3:0] RSQ_ADDR_OPTION = 4'h2;
  localparam logic [3:0] RSQ_ADDR_COUNTER_LO = 4'h4;
  localparam logic [3:0] RSQ_ADDR_COUNTER_HI = 4'h5;
  localparam logic [3:0] RSQ_ADDR_IRQ_ENABLE = 4'h6;
  localparam logic [3:0] RSQ_ADDR_IRQ_PEND = 4'h7;
  // Reset cause register bit positions.
  localparam int RSQ_BIT_POWERON = 7;
  localparam int RSQ_BIT_PIN = 6;
  localparam int RSQ_BIT_WATCHDOG = 5;
  localparam int RSQ_BIT_BADINSTR = 4;
  localparam int RSQ_BIT_BADFETCH = 3;
  localparam int RSQ_BIT_LOWVOLT = 1;
  localparam logic [7:0] RSQ_CAUSE_POR_VALUE = 8'h80;
  // Option register one bit positions and reset value.
  localparam int RSQ_BIT_STOP_ALLOW = 1;
  localparam int RSQ_BIT_SHORT_REC = 7;
  localparam logic [7:0] RSQ_OPTION_RESET = 8'h00;
  // Reset vector pairs.
  localparam logic [15:0] RSQ_VEC_USER = 16'hFFFE;
  localparam logic [15:0] RSQ_VEC_MONITOR = 16'hFEFE;
  // Timing counts in reference cycles.
  localparam int RSQ_CNT_WIDTH = 13;
  localparam logic [12:0] RSQ_PIN_DRIVE_CYCLES = 13'h0020;
  localparam logic [12:0] RSQ_HOLD_CYCLES = 13'h0020;
  localparam logic [12:0] RSQ_STAB_CYCLES = 13'h1000;
  localparam logic [12:0] RSQ_SHORT_REC_CYCLES = 13'h0020;
  localparam logic [12:0] RSQ_PIN_MIN_CYCLES = 13'h0043;
  localparam logic [12:0] RSQ_PIN_MIN_POR_CYCLES = 13'h1043;
  localparam int RSQ_NUM_IRQ = 8;
  // Sequencer states, one-hot.
  typedef enum logic [5:0] {
    RSQ_RUN = 6'h01,
    RSQ_STAB = 6'h02,
    RSQ_DRIVE = 6'h04,
    RSQ_HOLD = 6'h08,
    RSQ_STOP = 6'h10,
    RSQ_EXTRST = 6'h20
  } rsq_state_type;
  // Request from the core towards the exception arbiter.
  typedef struct packed {
    logic boundary;
    logic maskBit;
    logic swInstr;
    logic [RSQ_NUM_IRQ-1:0] req;
  } rsq_core_type;
  // Answer from the arbiter to the core.
  typedef struct packed {
    logic take;
    logic isSoft;
    logic [2:0] vecIndex;
    logic pushPcMinusOne;
    logic setMask;
  } rsq_exc_type;
endpackage
`default_nettype wire

/* rtl/rsq_sync.sv */
/*
  Three-stage synchroniser for asynchronous pin levels.
  Assumes inputs from outside the clock domain; the output changes only once the
  second and third stages agree.
*/
`default_nettype none
module rsq_sync
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // Shift the level through three stages and accept it on agreement.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      syncOut <= 1'b1;
    end
    else
    begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        syncOut <= s3_q;
    end
  end
endmodule
`default_nettype wire

/* testbench/rsq_pin_partner.sv */
/*
  Partner on the external reset line: the pull-up and any outside party pulling low.
  Assumes the bench raises pullLow to hold the line low for as long as it wishes.
*/
`default_nettype none
module rsq_pin_partner
(
  input wire logic pinOe,
  input wire logic pullLow,
  output logic pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line is low while either party pulls it; otherwise the pull-up wins.
  assign pinLevel = !(pinOe || pullLow);
endmodule
`default_nettype wire

/* testbench/tb_rsq_sequencer.sv */
/*
  Bench of the reset and exception sequencer: register tasks and directed tests.
  Assumes the 25 MHz clock and the pin partner on the external reset line.
*/
`default_nettype none
module tb_rsq_sequencer
  import rsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, reset_n = 1'h0, powerOnPulse = 1'h0, lowVoltage = 1'h0;
  logic watchdogOverflow = 1'h0, badOpcode = 1'h0, stopInstr = 1'h0, opcodeFetch = 1'h0;
  logic unmappedAddr = 1'h0, stopWake = 1'h0, monitorMode = 1'h0, breakState = 1'h0;
  logic testVoltRst = 1'h0, testVoltIrq = 1'h0, serviceWrite = 1'h0, pullLow = 1'h0;
  logic regWr = 1'h0, regRd = 1'h0, pinLevel, resetPinOut, resetPinOe, internalReset;
  logic busClocksOn, clockSourceOut, watchdogClear, watchdogTick, watchdogDisable;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, d;
  logic [15:0] resetVector;
  rsq_core_type core = '0;
  rsq_exc_type exc;
  int num_errors = 0, compares = 0, drv, hold, n;
  int bits[5] = '{RSQ_BIT_WATCHDOG, RSQ_BIT_BADINSTR, RSQ_BIT_BADINSTR, RSQ_BIT_BADFETCH,
    RSQ_BIT_LOWVOLT};
  logic [3:0] modes[5] = '{4'hA, 4'h9, 4'h6, 4'h3, 4'h5};
  logic [10:0] irqIn[6] = '{11'h40A, 11'h60A, 11'h00A, 11'h700, 11'h4C0, 11'h480};
  logic [3:0] irqExp[6] = '{4'h9, 4'h0, 4'h0, 4'h8, 4'hE, 4'h0};

  // The clock toggles every half period of 20 ns.
  always #20 clk = !clk;

  rsq_sequencer rsq_sequencer_i (.clk(clk), .reset_n(reset_n), .powerOnPulse(powerOnPulse),
    .lowVoltage(lowVoltage), .watchdogOverflow(watchdogOverflow), .badOpcode(badOpcode),
    .stopInstr(stopInstr), .opcodeFetch(opcodeFetch), .unmappedAddr(unmappedAddr),
    .stopWake(stopWake), .monitorMode(monitorMode), .breakState(breakState),
    .resetPinIn(pinLevel), .testVoltRst(testVoltRst), .testVoltIrq(testVoltIrq),
    .serviceWrite(serviceWrite), .core(core), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .internalReset(internalReset), .busClocksOn(busClocksOn),
    .clockSourceOut(clockSourceOut), .resetVector(resetVector),
    .watchdogClear(watchdogClear), .watchdogTick(watchdogTick),
    .watchdogDisable(watchdogDisable), .exc(exc));

  rsq_pin_partner rsq_pin_partner_i (.pinOe(resetPinOe), .pullLow(pullLow),
    .pinLevel(pinLevel));

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compares a seen value with the expected one and reports a mismatch.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Ends the run when a bounded wait has run out.
  task automatic bound(input logic ok);
    if (!ok)
    begin
      num_errors++;
      test_done();
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'h0;
  endtask

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    @(negedge clk);
    v = regRdata;
  endtask

  // Waits until internal reset is released.
  task automatic waitRun();
    n = 0;
    while (internalReset !== 1'h0 && n < 9000)
    begin
      @(negedge clk);
      n++;
    end
    bound(n < 9000);
  endtask

  // Counts the cycles of pin drive and of the internal-only hold that follows.
  task automatic measure();
    drv = 0;
    hold = 0;
    n = 0;
    while (resetPinOe !== 1'h1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    while (resetPinOe === 1'h1 && drv < 9000)
    begin
      @(negedge clk);
      drv++;
    end
    while (internalReset === 1'h1 && hold < 200)
    begin
      @(negedge clk);
      hold++;
    end
    bound(n < 50 && drv < 9000 && hold < 200);
  endtask

  // Holds the pin low from outside for len cycles and checks the pin cause flag.
  task automatic pinReset(input int len, input logic [15:0] flag);
    @(posedge clk);
    pullLow <= 1'h1;
    repeat (len) @(posedge clk);
    @(negedge clk);
    check("pinIrst", internalReset, 16'h0001);
    check("pinOe", resetPinOe, 16'h0000);
    @(posedge clk);
    pullLow <= 1'h0;
    repeat (5) @(posedge clk);
    waitRun();
    rd(RSQ_ADDR_CAUSE, d);
    check("pinFlag", d[RSQ_BIT_PIN], flag);
  endtask

  // Main sequence of directed tests.
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("porOe", resetPinOe, 16'h0001);
    check("porIrst", internalReset, 16'h0001);
    check("porClk", busClocksOn, 16'h0000);
    check("clkSrc", clockSourceOut, 16'h0001);
    check("pinOut", resetPinOut, 16'h0000);
    @(posedge clk);
    reset_n <= 1'h1;
    measure();
    check("porDrive", 16'(drv >= 4096), 16'h0001);
    check("porHold", 16'(hold), 16'h0020);
    check("busOn", busClocksOn, 16'h0001);
    check("vector", resetVector, RSQ_VEC_USER);
    rd(RSQ_ADDR_CAUSE, d);
    check("porCause", d, 16'(RSQ_CAUSE_POR_VALUE));
    wr(RSQ_ADDR_CAUSE, 8'hFF);
    rd(RSQ_ADDR_CAUSE, d);
    check("causeRo", d, 16'(RSQ_CAUSE_POR_VALUE));
    rd(4'hF, d);
    check("unmapped", d, 16'h0000);
    @(posedge clk);
    unmappedAddr <= 1'h1;
    @(posedge clk);
    unmappedAddr <= 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("dataAccess", internalReset, 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      wr(RSQ_ADDR_OPTION, 8'h80);
      @(posedge clk);
      case (i)
        0: watchdogOverflow <= 1'h1;
        1: badOpcode <= 1'h1;
        2: stopInstr <= 1'h1;
        3: {opcodeFetch, unmappedAddr} <= 2'h3;
        default: lowVoltage <= 1'h1;
      endcase
      @(posedge clk);
      {watchdogOverflow, badOpcode, stopInstr, opcodeFetch, unmappedAddr, lowVoltage} <= 6'h00;
      measure();
      if (i == 4)
        check("lvDrive", 16'(drv >= 4096), 16'h0001);
      else
        check("drive", 16'(drv), 16'h0020);
      check("hold", 16'(hold), 16'h0020);
      rd(RSQ_ADDR_CAUSE, d);
      check("cause", d[bits[i]], 16'h0001);
      rd(RSQ_ADDR_OPTION, d);
      check("option", d, 16'(RSQ_OPTION_RESET));
    end
    pinReset(30, 16'h0000);
    pinReset(80, 16'h0001);
    @(posedge clk);
    serviceWrite <= 1'h1;
    @(negedge clk);
    check("wdClear", watchdogClear, 16'h0001);
    @(posedge clk);
    serviceWrite <= 1'h0;
    rd(RSQ_ADDR_COUNTER_HI, d);
    check("cntHi", d, 16'h0000);
    n = 0;
    repeat (8192)
    begin
      @(negedge clk);
      n += watchdogTick;
    end
    check("ticks", 16'(n), 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      {monitorMode, breakState, testVoltRst, testVoltIrq} <= modes[i];
      repeat (6) @(posedge clk);
      @(negedge clk);
      check("wdDisable", watchdogDisable, 16'(i < 3));
      check("vector", resetVector, monitorMode ? RSQ_VEC_MONITOR : RSQ_VEC_USER);
    end
    @(posedge clk);
    {monitorMode, breakState, testVoltRst, testVoltIrq} <= 4'h0;
    wr(RSQ_ADDR_IRQ_ENABLE, 8'h7F);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      core <= rsq_core_type'(irqIn[i]);
      @(negedge clk);
      check("take", exc.take, irqExp[i][3]);
      if (irqExp[i][3])
      begin
        check("soft", exc.isSoft, 16'(i == 3));
        check("pcMinus", exc.pushPcMinusOne, 16'(i != 3));
        check("setMask", exc.setMask, 16'h0001);
        if (i != 3)
          check("vecIndex", exc.vecIndex, irqExp[i][2:0]);
      end
      @(posedge clk);
      core <= '0;
    end
    // A request latched between boundaries wins over a higher priority one that follows.
    @(posedge clk);
    core <= rsq_core_type'(11'h008);
    @(posedge clk);
    core <= rsq_core_type'(11'h403);
    @(negedge clk);
    check("latchTake", exc.take, 16'h0001);
    check("latchWins", exc.vecIndex, 16'h0003);
    @(posedge clk);
    core <= '0;
    for (int i = 0; i < 2; i++)
    begin
      wr(RSQ_ADDR_OPTION, i ? 8'h02 : 8'h82);
      @(posedge clk);
      stopInstr <= 1'h1;
      @(posedge clk);
      stopInstr <= 1'h0;
      repeat (40) @(posedge clk);
      @(negedge clk);
      check("stopClk", busClocksOn, 16'h0000);
      @(posedge clk);
      stopWake <= 1'h1;
      @(posedge clk);
      stopWake <= 1'h0;
      n = 0;
      while (busClocksOn !== 1'h1 && n < 9000)
      begin
        @(negedge clk);
        n++;
      end
      bound(n < 9000);
      check("stopRec", 16'(i ? n >= 4096 : n < 4096), 16'h0001);
    end
    test_done();
  end
endmodule
`default_nettype wire
